// File: rtl/iel_nest.sv
// Interrupt nesting counter and its two-bit level flag.
`timescale 1ns/1ps
`default_nettype none
module iel_nest (
   // Clock and reset.
   input  wire logic       i_clk,
   input  wire logic       i_rstn,
   // Counter controls.
   input  wire logic       i_inc,
   input  wire logic       i_dec,
   input  wire logic       i_clr,
   // Level flag.
   output logic [1:0]      o_flag
);

   typedef struct packed {
      logic [iel_pkg::NEST_W-1:0] cnt;
      logic [1:0]                 flag;
   } iel_nest_t;

   iel_nest_t s_reg;
   iel_nest_t s_next;

   // Clear wins; below zero the counter simply wraps, nothing flags it.
   always_comb begin
      s_next = s_reg;
      if (i_clr) begin
         s_next.cnt = iel_pkg::NEST_RESET;
      end else if (i_inc && !i_dec) begin
         s_next.cnt = s_reg.cnt + 4'h1;
      end else if (i_dec && !i_inc) begin
         s_next.cnt = s_reg.cnt - 4'h1;
      end
      s_next.flag = (s_next.cnt >= iel_pkg::NEST_SAT) ? 2'h3 : s_next.cnt[1:0];
   end

   // State register.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign o_flag = s_reg.flag;

   property p_nest_clr;
      @(posedge i_clk) disable iff (!i_rstn) i_clr |=> (o_flag == 2'h0);
   endproperty
   a_nest_clr: assert property (p_nest_clr) else $error("Nesting clear failed.");

   property p_nest_inc;
      @(posedge i_clk) disable iff (!i_rstn)
         (o_flag == 2'h0 && i_inc && !i_dec && !i_clr) |=> (o_flag == 2'h1);
   endproperty
   a_nest_inc: assert property (p_nest_inc) else $error("Nesting count-up failed.");

endmodule : iel_nest
`default_nettype wire

// File: rtl/iel_pkg.sv
// Shared constants, types and decode helpers for the interrupt enable and latch unit.
package iel_pkg;

   // Core clock and acceptance sequence timing.
   localparam int CLK_PERIOD_NS = 40;
   localparam int ACCEPT_MCYC   = 12;
   localparam int CLKS_PER_MCYC = 4;
   localparam int ACCEPT_CLKS   = ACCEPT_MCYC * CLKS_PER_MCYC;

   // Register indices; the byte address on the bus is four times the index.
   localparam logic [7:0] IDX_EN_TOP   = 8'h2a;
   localparam logic [7:0] IDX_LAT_TOP  = 8'h2b;
   localparam logic [7:0] IDX_EN_MIDL  = 8'h2c;
   localparam logic [7:0] IDX_EN_MIDH  = 8'h2d;
   localparam logic [7:0] IDX_LAT_MIDL = 8'h2e;
   localparam logic [7:0] IDX_LAT_MIDH = 8'h2f;
   localparam logic [7:0] IDX_EN_LOW   = 8'h3a;
   localparam logic [7:0] IDX_EN_HIGH  = 8'h3b;
   localparam logic [7:0] IDX_LAT_LOW  = 8'h3c;
   localparam logic [7:0] IDX_LAT_HIGH = 8'h3d;

   // Bank numbers: each bank holds eight source bits of the 40-bit vectors.
   localparam logic [2:0] BANK_LOW  = 3'h0;
   localparam logic [2:0] BANK_HIGH = 3'h1;
   localparam logic [2:0] BANK_MIDL = 3'h2;
   localparam logic [2:0] BANK_MIDH = 3'h3;
   localparam logic [2:0] BANK_TOP  = 3'h4;

   // Implemented source bits, field positions and reset values.
   localparam logic [39:0] EN_MASK      = 40'h5f05551548;
   localparam logic [39:0] LAT_MASK     = 40'h5f0555154c;
   localparam logic [39:0] EN_RESET     = 40'h0000000000;
   localparam logic [39:0] LAT_RESET    = 40'h0000000000;
   localparam logic        IMF_RESET    = 1'b0;
   localparam int          IMF_BIT      = 0;
   localparam int          PNMI_LAT_BIT = 2;
   localparam logic [5:0]  PNMI_EXT_ID  = 6'h00;
   localparam logic [5:0]  PNMI_LAT_ID  = 6'h02;
   localparam logic [7:0]  LOW_OTHER_LAT = 8'h48;

   // Nesting counter width, reset value and write commands.
   localparam int         NEST_W     = 4;
   localparam logic [3:0] NEST_RESET = 4'h0;
   localparam logic [3:0] NEST_SAT   = 4'h3;
   localparam logic [1:0] NEST_CLR   = 2'b01;
   localparam logic [1:0] NEST_DEC   = 2'b10;

   // Bus answer phase.
   typedef enum logic [0:0] {
      APB_IDLE = 1'b0,
      APB_ANS  = 1'b1
   } iel_apb_t;

   // Decoded register select.
   typedef struct packed {
      logic       hit;
      logic       is_lat;
      logic [2:0] bank;
   } iel_sel_t;

   // Whole state of the top module.
   typedef struct packed {
      logic [39:0] en;
      logic [39:0] lat;
      logic        master_irq_enable;
      logic        push_imf;
      logic        req;
      logic        pnmi;
      logic [5:0]  id;
      iel_apb_t    ph;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } iel_state_t;

   // Maps a byte address to a register, misaligned and stray addresses miss.
   function automatic iel_sel_t iel_decode(input logic [11:0] a);
      iel_sel_t s;
      s = '{hit: 1'b1, is_lat: 1'b0, bank: BANK_LOW};
      if (a[1:0] != 2'h0 || a[11:10] != 2'h0) begin
         s.hit = 1'b0;
      end
      unique case (a[9:2])
         IDX_EN_LOW:   s.bank = BANK_LOW;
         IDX_EN_HIGH:  s.bank = BANK_HIGH;
         IDX_EN_MIDL:  s.bank = BANK_MIDL;
         IDX_EN_MIDH:  s.bank = BANK_MIDH;
         IDX_EN_TOP:   s.bank = BANK_TOP;
         IDX_LAT_LOW:  s = '{hit: s.hit, is_lat: 1'b1, bank: BANK_LOW};
         IDX_LAT_HIGH: s = '{hit: s.hit, is_lat: 1'b1, bank: BANK_HIGH};
         IDX_LAT_MIDL: s = '{hit: s.hit, is_lat: 1'b1, bank: BANK_MIDL};
         IDX_LAT_MIDH: s = '{hit: s.hit, is_lat: 1'b1, bank: BANK_MIDH};
         IDX_LAT_TOP:  s = '{hit: s.hit, is_lat: 1'b1, bank: BANK_TOP};
         default:      s.hit = 1'b0;
      endcase
      return s;
   endfunction : iel_decode

   // Places one byte into its bank of a 40-bit vector.
   function automatic logic [39:0] iel_lane(input logic [2:0] b, input logic [7:0] d);
      return {32'h00000000, d} << {b, 3'b000};
   endfunction : iel_lane

endpackage : iel_pkg

// File: rtl/iel_seq.sv
// Acceptance sequence timer: busy for the whole twelve machine cycle sequence.
`timescale 1ns/1ps
`default_nettype none
module iel_seq (
   // Clock and reset.
   input  wire logic i_clk,
   input  wire logic i_rstn,
   // Sequence start and busy flag.
   input  wire logic i_start,
   output logic      o_busy
);

   typedef struct packed {
      logic       busy;
      logic [5:0] cnt;
   } iel_seq_t;

   iel_seq_t s_reg;
   iel_seq_t s_next;

   // A start while busy is ignored so that a sequence is never cut short.
   always_comb begin
      s_next = s_reg;
      if (i_start && !s_reg.busy) begin
         s_next.busy = 1'b1;
         s_next.cnt  = 6'(iel_pkg::ACCEPT_CLKS - 1);
      end else if (s_reg.busy) begin
         s_next.busy = (s_reg.cnt != 6'h00);
         s_next.cnt  = s_reg.cnt - 6'h01;
      end
   end

   // State register.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign o_busy = s_reg.busy;

   localparam int A_HOLD = iel_pkg::ACCEPT_CLKS - 1;

   sequence s_seq_hold;
      ##A_HOLD o_busy ##1 !o_busy;
   endsequence

   property p_seq_len;
      @(posedge i_clk) disable iff (!i_rstn) $rose(o_busy) |-> s_seq_hold;
   endproperty
   a_seq_len: assert property (p_seq_len) else $error("Acceptance sequence length wrong.");

endmodule : iel_seq
`default_nettype wire

// File: rtl/iel_unit.sv
// Interrupt enable and latch unit with its bus slave and core handshake.
//
// Operation
// - Pseudo non-maskable requests ignore all enable bits.
// - Enable registers at their five addresses, read/write.
// - Master enable zero blocks every maskable request.
// - Maskable needs master and own enable set.
// - Acceptance pushes master enable, then clears it.
// - Maskable return sets master enable.
// - Pending request taken right after maskable return.
// - Non-maskable return restores the stacked master enable.
// - Master enable is bit 0, resets zero.
// - Source enables gate their source, reset zero.
// - Latch reads pending; write 0 clears, 1 nothing.
// - Source 2 latch not clearable alone.
// - Nesting flag shows service depth.
// - Nesting write 01 clears, 10 counts down.
// - No underflow detection on the nesting counter.
// - Nesting counter counts acceptances minus returns.
// - Source event sets latch, acceptance clears it.
// - Acceptance sequence lasts twelve machine cycles.
`timescale 1ns/1ps
`default_nettype none
module iel_unit (
   // Clock and reset.
   input  wire logic        I_CORE_CLK,
   input  wire logic        I_RSTN,

   // APB slave.
   input  wire logic        I_PSEL,
   input  wire logic        I_PENABLE,
   input  wire logic        I_PWRITE,
   input  wire logic [11:0] I_PADDR,
   input  wire logic [31:0] I_PWDATA,
   input  wire logic [3:0]  I_PSTRB,
   output logic             O_PREADY,
   output logic [31:0]      O_PRDATA,
   output logic             O_PSLVERR,

   // Interrupt sources.
   input  wire logic [39:0] I_IRQ_SRC,
   input  wire logic        I_PNMI_REQ,

   // Core sequencer events.
   input  wire logic        I_ACCEPT,
   input  wire logic        I_MASKABLE_RETURN_INSTR,
   input  wire logic        I_NMI_RETURN_INSTR,
   input  wire logic        I_RET_IMF,
   input  wire logic        I_EI,
   input  wire logic        I_DI,

   // Request and status towards the core.
   output logic             O_IRQ_REQ,
   output logic [5:0]       O_IRQ_ID,
   output logic             O_IRQ_PNMI,
   output logic             O_PUSH_IMF,
   output logic             O_SEQ_BUSY,
   output logic             O_IMF,
   output logic [1:0]       O_NEST_FLAG
);

   iel_pkg::iel_state_t s_reg;
   iel_pkg::iel_state_t s_next;

   iel_pkg::iel_sel_t   sel;

   logic        seq_busy;
   logic [1:0]  nest_flag;
   logic        accept_ok;
   logic        bus_done;
   logic        wr;
   logic        wr_lat0;
   logic        nest_inc;
   logic        nest_dec;
   logic        nest_clr;
   logic [39:0] set_vec;
   logic [39:0] clr_vec;
   logic [39:0] bank_mask;
   logic [39:0] lane;
   logic [39:0] pend;
   logic [39:0] rd_vec;

   // Lowest set bit wins, so pseudo non-maskable sources come first.
   function automatic logic [5:0] lowest(input logic [39:0] p);
      logic [5:0] r;
      r = 6'h00;
      for (int i = 39; i >= 0; i--) begin
         if (p[i]) begin
            r = 6'(i);
         end
      end
      return r;
   endfunction : lowest

   // Address decode and bus qualifiers.
   assign sel       = iel_pkg::iel_decode(I_PADDR);
   assign bus_done  = I_PSEL && I_PENABLE && (s_reg.ph == iel_pkg::APB_ANS);
   assign wr        = bus_done && I_PWRITE && sel.hit && I_PSTRB[0];
   assign wr_lat0   = wr && sel.is_lat && (sel.bank == iel_pkg::BANK_LOW);
   assign accept_ok = I_ACCEPT && s_reg.req && !seq_busy;
   assign lane      = iel_pkg::iel_lane(sel.bank, I_PWDATA[7:0]);
   assign bank_mask = iel_pkg::iel_lane(sel.bank, 8'hff);
   assign set_vec   = I_IRQ_SRC & iel_pkg::LAT_MASK;

   // Nesting counter controls; a return from either kind counts down.
   assign nest_inc = accept_ok;
   assign nest_clr = wr_lat0 && (I_PWDATA[1:0] == iel_pkg::NEST_CLR);
   assign nest_dec = I_MASKABLE_RETURN_INSTR || I_NMI_RETURN_INSTR || (wr_lat0 && (I_PWDATA[1:0] == iel_pkg::NEST_DEC));

   // Next state: latches, enables, master enable, request and bus answer.
   always_comb begin
      s_next  = s_reg;
      clr_vec = 40'h0000000000;
      pend    = 40'h0000000000;
      rd_vec  = 40'h0000000000;

      // Software clears only where it writes zero to a real latch.
      if (wr && sel.is_lat) begin
         clr_vec = ~lane & bank_mask & iel_pkg::LAT_MASK;
         if ((clr_vec & ~(40'h0000000001 << iel_pkg::PNMI_LAT_BIT)) == 40'h0000000000) begin
            clr_vec[iel_pkg::PNMI_LAT_BIT] = 1'b0;
         end
      end

      // The accepted source gives up its latch; the external pseudo request has none.
      if (accept_ok && s_reg.id != iel_pkg::PNMI_EXT_ID) begin
         clr_vec[s_reg.id] = 1'b1;
      end

      // A source event in the same cycle as a clear keeps the latch set.
      s_next.lat = (s_reg.lat & ~clr_vec) | set_vec;

      // Enable writes; bit 0 of the low bank is the master enable.
      if (wr && !sel.is_lat) begin
         s_next.en = (s_reg.en & ~bank_mask) | (lane & bank_mask & iel_pkg::EN_MASK);
         if (sel.bank == iel_pkg::BANK_LOW) begin
            s_next.master_irq_enable = I_PWDATA[iel_pkg::IMF_BIT];
         end
      end

      // Core instructions override a bus write landing in the same cycle.
      if (I_EI) begin
         s_next.master_irq_enable = 1'b1;
      end else if (I_DI) begin
         s_next.master_irq_enable = 1'b0;
      end

      // Returns restore the master enable.
      if (I_MASKABLE_RETURN_INSTR) begin
         s_next.master_irq_enable = 1'b1;
      end else if (I_NMI_RETURN_INSTR) begin
         s_next.master_irq_enable = I_RET_IMF;
      end

      // Acceptance stacks the old value first, then masks.
      if (accept_ok) begin
         s_next.push_imf = s_reg.master_irq_enable;
         s_next.master_irq_enable      = 1'b0;
      end

      // Acceptable requests are judged on the next state, so a return opens the gate at once.
      pend = s_next.lat & s_next.en & iel_pkg::EN_MASK & {40{s_next.master_irq_enable}};
      pend[iel_pkg::PNMI_LAT_BIT] = s_next.lat[iel_pkg::PNMI_LAT_BIT];
      pend[0] = I_PNMI_REQ;

      s_next.req  = (pend != 40'h0000000000) && !seq_busy && !I_ACCEPT;
      s_next.id   = lowest(pend);
      s_next.pnmi = (s_next.id == iel_pkg::PNMI_EXT_ID) || (s_next.id == iel_pkg::PNMI_LAT_ID);

      // Read view: master enable and nesting flag fill the spare low bits.
      if (sel.is_lat) begin
         rd_vec = s_reg.lat | {38'h0000000000, nest_flag};
      end else begin
         rd_vec = s_reg.en | {39'h0000000000, s_reg.master_irq_enable};
      end
      rd_vec = rd_vec >> {sel.bank, 3'b000};

      // One wait state: data is sampled at the first access edge, written at the last edge.
      unique case (s_reg.ph)
         iel_pkg::APB_IDLE: begin
            if (I_PSEL && I_PENABLE) begin
               s_next.ph      = iel_pkg::APB_ANS;
               s_next.pready  = 1'b1;
               s_next.pslverr = !sel.hit;
               s_next.prdata  = sel.hit ? {24'h000000, rd_vec[7:0]} : 32'h00000000;
            end
         end
         iel_pkg::APB_ANS: begin
            s_next.ph      = iel_pkg::APB_IDLE;
            s_next.pready  = 1'b0;
            s_next.pslverr = 1'b0;
         end
      endcase
   end

   // State register; reset leaves every enable and latch cleared.
   always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         s_reg          <= '0;
         s_reg.en       <= iel_pkg::EN_RESET;
         s_reg.lat      <= iel_pkg::LAT_RESET;
         s_reg.master_irq_enable      <= iel_pkg::IMF_RESET;
         s_reg.ph       <= iel_pkg::APB_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end

   // Acceptance sequence timer.
   iel_seq u_seq (
      .i_clk   (I_CORE_CLK),
      .i_rstn  (I_RSTN),
      .i_start (accept_ok),
      .o_busy  (seq_busy)
   );

   // Nesting counter.
   iel_nest u_nest (
      .i_clk  (I_CORE_CLK),
      .i_rstn (I_RSTN),
      .i_inc  (nest_inc),
      .i_dec  (nest_dec),
      .i_clr  (nest_clr),
      .o_flag (nest_flag)
   );

   // Outputs straight from the state flops.
   assign O_PREADY    = s_reg.pready;
   assign O_PRDATA    = s_reg.prdata;
   assign O_PSLVERR   = s_reg.pslverr;
   assign O_IRQ_REQ   = s_reg.req;
   assign O_IRQ_ID    = s_reg.id;
   assign O_IRQ_PNMI  = s_reg.pnmi;
   assign O_PUSH_IMF  = s_reg.push_imf;
   assign O_SEQ_BUSY  = seq_busy;
   assign O_IMF       = s_reg.master_irq_enable;
   assign O_NEST_FLAG = nest_flag;

   property p_pnmi_any;
      @(posedge I_CORE_CLK) disable iff (!I_RSTN)
         (s_reg.lat[2] && !$past(seq_busy) && !$past(I_ACCEPT)) |-> s_reg.req;
   endproperty
   a_pnmi_any: assert property (p_pnmi_any) else $error("Pseudo request was gated.");

   property p_mask_gate;
      @(posedge I_CORE_CLK) disable iff (!I_RSTN) (s_reg.req && !s_reg.pnmi) |-> s_reg.master_irq_enable;
   endproperty
   a_mask_gate: assert property (p_mask_gate) else $error("Request with master off.");

   property p_src_gate;
      @(posedge I_CORE_CLK) disable iff (!I_RSTN)
         (s_reg.req && !s_reg.pnmi) |-> (s_reg.en[s_reg.id] && s_reg.lat[s_reg.id]);
   endproperty
   a_src_gate: assert property (p_src_gate) else $error("Request without enable.");

   property p_accept_push;
      @(posedge I_CORE_CLK) disable iff (!I_RSTN)
         accept_ok |=> (!s_reg.master_irq_enable && (s_reg.push_imf == $past(s_reg.master_irq_enable)));
   endproperty
   a_accept_push: assert property (p_accept_push) else $error("Acceptance did not stack.");

   property p_maskable_return_instr_set;
      @(posedge I_CORE_CLK) disable iff (!I_RSTN) (I_MASKABLE_RETURN_INSTR && !accept_ok) |=> s_reg.master_irq_enable;
   endproperty
   a_maskable_return_instr_set: assert property (p_maskable_return_instr_set) else $error("Return left master off.");

   sequence s_maskable_return_instr_pend;
      I_MASKABLE_RETURN_INSTR && !accept_ok && !I_ACCEPT && !seq_busy && !wr && !I_DI
         && ((s_reg.lat & s_reg.en & iel_pkg::EN_MASK) != 40'h0000000000);
   endsequence

   property p_maskable_return_instr_take;
      @(posedge I_CORE_CLK) disable iff (!I_RSTN) s_maskable_return_instr_pend |=> s_reg.req;
   endproperty
   a_maskable_return_instr_take: assert property (p_maskable_return_instr_take) else $error("Pending not raised after return.");

   property p_write_one;
      @(posedge I_CORE_CLK) disable iff (!I_RSTN)
         (wr && sel.is_lat && I_PWDATA[7:0] == 8'hff && !accept_ok) |=> ((($past(s_reg.lat)) & ~s_reg.lat) == '0);
   endproperty
   a_write_one: assert property (p_write_one) else $error("Writing one cleared a latch.");

   property p_src2_keep;
      @(posedge I_CORE_CLK) disable iff (!I_RSTN)
         (s_reg.lat[2] && wr_lat0 && !accept_ok
          && ((I_PWDATA[7:0] & iel_pkg::LOW_OTHER_LAT) == iel_pkg::LOW_OTHER_LAT)) |=> s_reg.lat[2];
   endproperty
   a_src2_keep: assert property (p_src2_keep) else $error("Source 2 cleared alone.");

   property p_latch_set;
      @(posedge I_CORE_CLK) disable iff (!I_RSTN)
         (set_vec != 40'h0000000000) |=> ((s_reg.lat & $past(set_vec)) == $past(set_vec));
   endproperty
   a_latch_set: assert property (p_latch_set) else $error("Source event lost.");

endmodule : iel_unit
`default_nettype wire

// File: sim/iel_core_model.sv
// Core sequencer model that accepts the unit's request after a set delay.
`timescale 1ns/1ps
`default_nettype none
module iel_core_model (
   // Clock and reset.
   input  wire logic       i_clk,
   input  wire logic       i_rstn,
   // Bench controls: accept on or off, and cycles to wait before accepting.
   input  wire logic       i_go,
   input  wire logic [1:0] i_delay,
   // Request from the unit.
   input  wire logic       i_req,
   input  wire logic       i_busy,
   input  wire logic [5:0] i_id,
   // Accept pulse and the id taken with it.
   output logic            o_accept,
   output logic [5:0]      o_id
);
   logic [1:0] cnt_reg;

   // One pulse per request; the guard on o_accept stops a second pulse before busy shows.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_accept <= 1'b0;
         o_id     <= 6'h00;
         cnt_reg  <= 2'h0;
      end else begin
         o_accept <= 1'b0;
         cnt_reg  <= 2'h0;
         if (i_go && i_req && !i_busy && !o_accept) begin
            if (cnt_reg == i_delay) begin
               o_accept <= 1'b1;
               o_id     <= i_id;
            end else begin
               cnt_reg <= cnt_reg + 2'h1;
            end
         end
      end
   end
endmodule : iel_core_model
`default_nettype wire

// File: sim/tb.sv
// Self-checking testbench for the interrupt enable and latch unit.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        clk, rstn, psel, penable, pwrite, pnmi_req, maskable_return_instr, nmi_return_instr, ret_imf, ei, di, go, accept;
   logic        pready, pslverr, irq_req, irq_pnmi, push_imf, seq_busy, master_irq_enable;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pstrb;
   logic [39:0] src;
   logic [5:0]  irq_id, seen_id;
   logic [1:0]  nest, dly;
   int          miscompares, compares, n;

   iel_unit u_iel_unit (.I_CORE_CLK(clk), .I_RSTN(rstn), .I_PSEL(psel), .I_PENABLE(penable),
      .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb), .O_PREADY(pready),
      .O_PRDATA(prdata), .O_PSLVERR(pslverr), .I_IRQ_SRC(src), .I_PNMI_REQ(pnmi_req), .I_ACCEPT(accept),
      .I_MASKABLE_RETURN_INSTR(maskable_return_instr), .I_NMI_RETURN_INSTR(nmi_return_instr), .I_RET_IMF(ret_imf), .I_EI(ei), .I_DI(di), .O_IRQ_REQ(irq_req),
      .O_IRQ_ID(irq_id), .O_IRQ_PNMI(irq_pnmi), .O_PUSH_IMF(push_imf), .O_SEQ_BUSY(seq_busy),
      .O_IMF(master_irq_enable), .O_NEST_FLAG(nest));
   iel_core_model u_iel_core_model (.i_clk(clk), .i_rstn(rstn), .i_go(go), .i_delay(dly),
      .i_req(irq_req), .i_busy(seq_busy), .i_id(irq_id), .o_accept(accept), .o_id(seen_id));

   // Free running core clock.
   initial begin
      clk = 1'b0;
      forever #(iel_pkg::CLK_PERIOD_NS / 2) clk = ~clk;
   end

   // Compares one value and counts the result.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   // One bus transfer; the request is held until pready is sampled high.
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= {2'h0, idx, 2'h0};
      pwdata  <= {24'h000000, wd};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      chk({31'h0, pready}, 32'h1, "bus answer");
      rd = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Reads a register and compares it.
   task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 8'h00);
      chk(rd, exp, "register read");
   endtask : rdchk

   // Pulses core events {return, non-maskable return, enable, mask}; returns when the effect shows.
   task automatic ev(input logic [3:0] k);
      @(posedge clk);
      {maskable_return_instr, nmi_return_instr, ei, di} <= k;
      @(posedge clk);
      {maskable_return_instr, nmi_return_instr, ei, di} <= 4'h0;
      @(posedge clk);
   endtask : ev

   // One-cycle source events.
   task automatic srcp(input logic [39:0] m);
      @(posedge clk);
      src <= m;
      @(posedge clk);
      src <= '0;
      @(posedge clk);
   endtask : srcp

   // Waits, bounded, for the sequence busy flag to reach a level.
   task automatic wait_busy(input logic lvl);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (seq_busy !== lvl && n < 200);
      chk({31'h0, seq_busy}, {31'h0, lvl}, "busy level");
   endtask : wait_busy

   // Reset values, bus map and unmapped access.
   task automatic t_regs;
      logic [7:0] ix [5] = '{iel_pkg::IDX_EN_LOW, iel_pkg::IDX_EN_HIGH, iel_pkg::IDX_EN_MIDL,
                             iel_pkg::IDX_EN_MIDH, iel_pkg::IDX_EN_TOP};
      rdchk(iel_pkg::IDX_EN_LOW, 32'h0);
      rdchk(iel_pkg::IDX_LAT_LOW, 32'h0);
      apb(1'b0, 8'h30, 8'h00);
      chk({31'h0, pslverr}, 32'h1, "unmapped error");
      // Bit 0 stays clear so the master enable never rises with the sources.
      for (int b = 0; b < 5; b++) begin
         apb(1'b1, ix[b], 8'hfe);
         rdchk(ix[b], {24'h0, iel_pkg::EN_MASK[8*b+:8] & 8'hfe});
         apb(1'b1, ix[b], 8'h00);
      end
      $display("test regs done");
   endtask : t_regs

   // Enable gating by source flag and master flag.
   task automatic t_gate;
      apb(1'b1, iel_pkg::IDX_EN_LOW, 8'h08);
      srcp(40'h40);
      ev(4'h2);
      chk({31'h0, irq_req}, 32'h0, "source disabled");
      rdchk(iel_pkg::IDX_LAT_LOW, 32'h40);
      ev(4'h1);
      srcp(40'h08);
      chk({31'h0, irq_req}, 32'h0, "master clear");
      ev(4'h2);
      chk({31'h0, irq_req}, 32'h1, "request");
      chk({26'h0, irq_id}, 32'h3, "request id");
      $display("test gate done");
   endtask : t_gate

   // Acceptance and its sequence length.
   task automatic t_accept;
      go <= 1'b1;
      wait_busy(1'b1);
      go <= 1'b0;
      chk({31'h0, master_irq_enable}, 32'h0, "master after accept");
      chk({31'h0, push_imf}, 32'h1, "stacked master");
      chk({30'h0, nest}, 32'h1, "nesting level one");
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (seq_busy === 1'b1 && n < 100);
      chk(n, iel_pkg::ACCEPT_CLKS, "sequence length");
      rdchk(iel_pkg::IDX_LAT_LOW, 32'h41);
      $display("test accept done");
   endtask : t_accept

   // Return takes the next pending request at once, lowest source first.
   task automatic t_maskable_return_instr;
      apb(1'b1, iel_pkg::IDX_EN_LOW, 8'h48);
      srcp(40'h08);
      go <= 1'b1;
      ev(4'h8);
      wait_busy(1'b1);
      chk(n, 32'h2, "accept after return");
      chk({26'h0, seen_id}, 32'h3, "lowest first");
      chk({30'h0, nest}, 32'h1, "nesting after return and accept");
      go <= 1'b0;
      wait_busy(1'b0);
      ev(4'h8);
      chk({31'h0, master_irq_enable}, 32'h1, "master after return");
      chk({30'h0, nest}, 32'h0, "nesting back to zero");
      chk({26'h0, irq_id}, 32'h6, "next request");
      $display("test maskable_return_instr done");
   endtask : t_maskable_return_instr

   // Latch clearing by plain writes, source 2 only together with another.
   task automatic t_latch;
      ev(4'h1);
      srcp(40'h4c);
      apb(1'b1, iel_pkg::IDX_LAT_LOW, 8'hff);
      rdchk(iel_pkg::IDX_LAT_LOW, 32'h4c);
      apb(1'b1, iel_pkg::IDX_LAT_LOW, 8'hfb);
      rdchk(iel_pkg::IDX_LAT_LOW, 32'h4c);
      apb(1'b1, iel_pkg::IDX_LAT_LOW, 8'hbf);
      rdchk(iel_pkg::IDX_LAT_LOW, 32'h0c);
      apb(1'b1, iel_pkg::IDX_LAT_LOW, 8'hf3);
      rdchk(iel_pkg::IDX_LAT_LOW, 32'h00);
      $display("test latch done");
   endtask : t_latch

   // Nesting commands: count down from zero wraps, clear returns to zero.
   task automatic t_nest;
      apb(1'b1, iel_pkg::IDX_LAT_LOW, 8'hfe);
      rdchk(iel_pkg::IDX_LAT_LOW, 32'h03);
      apb(1'b1, iel_pkg::IDX_LAT_LOW, 8'hfd);
      rdchk(iel_pkg::IDX_LAT_LOW, 32'h00);
      $display("test nest done");
   endtask : t_nest

   // Pseudo non-maskable request with master clear and set, slow core answer.
   task automatic t_pnmi;
      dly <= 2'h3;
      for (int v = 0; v < 2; v++) begin
         ev(v ? 4'h2 : 4'h1);
         pnmi_req <= 1'b1;
         repeat (2) @(posedge clk);
         chk({31'h0, irq_req}, 32'h1, "pseudo request");
         chk({31'h0, irq_pnmi}, 32'h1, "pseudo kind");
         go <= 1'b1;
         wait_busy(1'b1);
         pnmi_req <= 1'b0;
         go <= 1'b0;
         chk({26'h0, seen_id}, 32'h0, "pseudo id");
         chk({31'h0, push_imf}, v, "stacked master");
         ret_imf <= v[0];
         wait_busy(1'b0);
         ev(4'h4);
         chk({31'h0, master_irq_enable}, v, "master after non-maskable return");
      end
      $display("test pnmi done");
   endtask : t_pnmi

   // Prints the counts and the verdict, then stops.
   task automatic results;
      $display("comparisons %0d mismatches %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : results

   // Main sequence.
   initial begin
      {rstn, psel, penable, pwrite, pnmi_req, maskable_return_instr, nmi_return_instr, ret_imf, ei, di, go} = '0;
      {paddr, pwdata, src, dly} = '0;
      pstrb = 4'hf;
      miscompares = 0;
      compares = 0;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      t_regs();
      t_gate();
      t_accept();
      t_maskable_return_instr();
      t_latch();
      t_nest();
      t_pnmi();
      results();
   end

   // Watchdog: the tests need well under two thousand cycles.
   initial begin
      #(iel_pkg::CLK_PERIOD_NS * 20000);
      miscompares++;
      results();
   end
endmodule : tb
`default_nettype wire
